//--- mms_pkg.sv
// Constants, configuration layouts and state types for the six-port
// multi-mode serial block. Assumes one system clock of 10 MHz.
package mms_pkg;
  localparam int NPORT = 6;
  localparam int AW = 5;
  localparam int DW = 16;
  localparam int PORT_A = 0;
  localparam int PORT_B = 1;
  localparam int FIRST_HDLC = 4;
  localparam logic [2:0] SEL_GLOBAL = 3'h6;
  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_DIV = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  localparam logic [1:0] REG_IST = 2'h0;
  localparam logic [1:0] REG_IMSK = 2'h1;
  localparam logic [1:0] REG_MISC = 2'h2;
  localparam logic [1:0] REG_PINS = 2'h3;
  localparam logic [15:0] MIN_DIV = 16'h0008;
  localparam logic [15:0] DIV_RST = 16'h0010;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [7:0] HDLC_FLAG = 8'h7e;
  localparam logic [2:0] STUFF_ONES = 3'h5;
  localparam logic [2:0] ABORT_ONES = 3'h7;
  localparam logic [4:0] HDLC_LEN = 5'h18;
  localparam logic [4:0] CLKD_LEN = 5'h08;
  localparam logic [4:0] STUFF_LO = 5'h09;
  localparam logic [4:0] STUFF_HI = 5'h10;
  localparam logic [4:0] FRAME_OVH = 5'h02;
  localparam logic [3:0] SEVEN_BITS = 4'h7;
  localparam logic [3:0] EIGHT_BITS = 4'h8;
  localparam logic [3:0] RSH_W = 4'ha;
  localparam logic [3:0] CLKD_SKIP = 4'h2;
  localparam logic [1:0] BOOT_COLD = 2'h0;
  localparam logic [1:0] BOOT_WAIT = 2'h3;
  localparam logic [1:0] ST_FETCH = 2'h0;
  localparam logic [1:0] ST_INTACK = 2'h1;

  typedef struct packed {
    logic irda;
    logic hdlc;
    logic extclk;
    logic clkd;
    logic addr;
    logic brkinh;
    logic seven;
  } mms_cfg_s;

  localparam mms_cfg_s CFG_RST = 7'h00;
  localparam mms_cfg_s CFG_RST_B = 7'h08;

  typedef struct packed {
    logic [1:0] stmode;
    logic gpo;
    logic a_out;
    logic a_oe;
  } mms_misc_s;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_BITS = 4'h4,
    RX_BRK = 4'h8
  } mms_rx_e;

  typedef struct packed {
    logic [23:0] tsh;
    logic [4:0] tlen;
    logic [2:0] tones;
    logic tseen;
    logic [15:0] bcnt;
    logic tbit;
    logic pin;
    logic sclk;
    logic sclkoe;
    mms_rx_e rst;
    logic [15:0] rdiv;
    logic [9:0] rsh;
    logic [3:0] rcnt;
    logic allz;
    logic [8:0] rbuf;
    logic rfull;
    logic [7:0] hist;
    logic [2:0] rones;
    logic hsync;
    logic irlow;
    logic ev_rx;
    logic ev_brk;
  } mms_port_s;

  localparam mms_port_s PORT_RST = '{tbit: 1'b1, pin: 1'b1, sclk: 1'b1,
    rst: RX_IDLE, default: '0};
endpackage

//--- mms_serial_ports.sv
// Six serial ports with async, clocked and bit-synchronous framing.
// Assumes a single-cycle register master on the system clock; serial, clock
// and boot-select pins come from outside that domain and are synchronised here.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Async bit time is at least eight clocks.
// - Seven or eight data bits per port.
// - Addressed mode adds a mark bit after the last data bit.
// - Clocked mode, clock from us or peer.
// - Ports E and F offer HDLC framing.
// - IrDA pulse coding inside HDLC mode.
// - Line held low reports a break.
// - Control bit 1 inhibits assembly during break.
// - Receive clock pairs with transmit data port.
// - Port B drives flash shift clock.
// - Port A clock pin is GPIO when async.
// - Boot selects sampled after reset.
// - Status pin: fetch, acknowledge or GPO.
module mms_serial_ports
  import mms_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DW-1:0] reg_rdata_o,
  output logic irq_o,
  input wire logic [NPORT-1:0] serial_in_i,
  output logic [NPORT-1:0] serial_out_o,
  input wire logic [NPORT-1:0] shift_clk_i,
  output logic [NPORT-1:0] shift_clk_o,
  output logic [NPORT-1:0] shift_clk_oe_o,
  input wire logic [1:0] receive_clk_i,
  input wire logic boot_select_0_i,
  input wire logic boot_select_1_i,
  output logic boot_cold_o,
  output logic boot_valid_o,
  input wire logic first_fetch_i,
  input wire logic int_ack_i,
  output logic status_n_o
);
  logic [15:0] s1_r, s2_r, s3_r;
  logic [NPORT-1:0] in_s, ck_s, ck_p;
  logic [1:0] rc_s, rc_p, bsel;
  logic [2:0] sel;
  logic [1:0] off;
  mms_cfg_s cfg_r [NPORT];
  mms_cfg_s cfg_nxt [NPORT];
  logic [15:0] div_r [NPORT];
  logic [15:0] div_nxt [NPORT];
  mms_port_s prt [NPORT];
  logic [11:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
  mms_misc_s misc_r, misc_nxt;
  logic [DW-1:0] rdata_nxt;
  logic irq_nxt, status_nxt, cold_nxt, valid_nxt;
  logic [1:0] bwait_r, bwait_nxt;

  assign sel = reg_addr_i[4:2];
  assign off = reg_addr_i[1:0];
  assign in_s = s2_r[15:10];
  assign ck_s = s2_r[9:4];
  assign ck_p = s3_r[9:4];
  assign rc_s = s2_r[3:2];
  assign rc_p = s3_r[3:2];
  assign bsel = s2_r[1:0];

  // Lines idle high, so the synchronisers start high to avoid a false
  // start bit or clock edge straight after reset.
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end
    else
    begin
      s1_r <= {serial_in_i, shift_clk_i, receive_clk_i, boot_select_1_i,
        boot_select_0_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  for (genvar i = 0; i < NPORT; i++)
  begin : g_port
    mms_port_s p, n;
    mms_cfg_s c;
    logic [15:0] per;
    logic [23:0] frm;
    logic [8:0] ext;
    logic [9:0] rsh_in, al;
    logic [3:0] nbits, kbits;
    logic btick, htick, rise, fall, shift, samp, rb, hb, drvclk;
    logic quarter, wr_d, rd_d, rck, rckp;

    if (i >= FIRST_HDLC)
    begin : g_rc
      assign rck = rc_s[i-FIRST_HDLC];
      assign rckp = rc_p[i-FIRST_HDLC];
    end
    else
    begin : g_norc
      assign rck = 1'b0;
      assign rckp = 1'b0;
    end

    assign c = cfg_r[i];
    assign wr_d = reg_wr_i && sel == 3'(i) && off == REG_DATA;
    assign rd_d = reg_rd_i && sel == 3'(i) && off == REG_DATA;
    assign prt[i] = p;
    assign serial_out_o[i] = p.pin;
    assign shift_clk_o[i] = p.sclk;
    assign shift_clk_oe_o[i] = p.sclkoe;

    always_comb
    begin
      n = p;
      n.ev_rx = 1'b0;
      n.ev_brk = 1'b0;
      per = (div_r[i] < MIN_DIV) ? MIN_DIV : div_r[i];
      btick = p.bcnt == per - ONE16;
      htick = p.bcnt == (per >> 1);
      drvclk = c.hdlc || (c.clkd && !c.extclk);
      rise = ck_s[i] && !ck_p[i];
      fall = !ck_s[i] && ck_p[i];
      nbits = c.seven ? SEVEN_BITS : EIGHT_BITS;
      kbits = nbits + {3'h0, c.addr};
      rb = in_s[i];
      hb = c.irda ? !p.irlow : rb;
      rsh_in = {rb, p.rsh[9:1]};
      // The mark bit travels just above the data bits.
      ext = c.seven
        ? {1'b1, c.addr ? reg_wdata_i[8] : 1'b1, reg_wdata_i[6:0]}
        : {c.addr ? reg_wdata_i[8] : 1'b1, reg_wdata_i[7:0]};
      frm = c.hdlc ? {HDLC_FLAG, reg_wdata_i[7:0], HDLC_FLAG}
        : c.clkd ? {16'hffff, reg_wdata_i[7:0]}
        : {13'h1fff, 1'b1, ext, 1'b0};
      shift = (c.clkd && !c.hdlc && c.extclk) ? (fall && p.tseen) : btick;
      samp = c.hdlc ? (rck && !rckp)
        : c.extclk ? rise : (htick && p.tlen != '0);
      al = p.rsh >> (RSH_W - kbits);
      if (rd_d)
        n.rfull = 1'b0;

      n.bcnt = (btick || p.tlen == '0) ? '0 : p.bcnt + ONE16;
      if (rise)
        n.tseen = 1'b1;
      if (wr_d && p.tlen == '0)
      begin
        n.tsh = frm >> 1;
        n.tbit = frm[0];
        n.tlen = c.hdlc ? HDLC_LEN : c.clkd ? CLKD_LEN
          : {1'b0, kbits} + FRAME_OVH;
        n.bcnt = '0;
        n.tones = '0;
        n.tseen = 1'b0;
      end
      else if (p.tlen != '0 && shift)
      begin
        if (c.hdlc && p.tones == STUFF_ONES)
        begin
          n.tbit = 1'b0;
          n.tones = '0;
        end
        else
        begin
          n.tlen = p.tlen - 5'h01;
          n.tbit = (n.tlen == '0) ? 1'b1 : p.tsh[0];
          n.tsh = p.tsh >> 1;
          n.tones = (n.tlen >= STUFF_LO && n.tlen <= STUFF_HI && p.tsh[0])
            ? p.tones + 3'h1 : '0;
        end
      end
      quarter = n.bcnt < (per >> 2);
      n.pin = (c.hdlc && c.irda && n.tlen != '0)
        ? !(!n.tbit && quarter) : n.tbit;
      if (i == PORT_A && !c.clkd)
      begin
        n.sclk = misc_r.a_out;
        n.sclkoe = misc_r.a_oe;
      end
      else
      begin
        // Port B resets as clock master for the serial flash.
        n.sclk = !(drvclk && n.tlen != '0 && n.bcnt < (per >> 1));
        n.sclkoe = drvclk;
      end

      n.rdiv = p.rdiv + ONE16;
      n.irlow = p.irlow || !rb;
      if (c.hdlc)
      begin
        n.rst = RX_IDLE;
        if (samp)
        begin
          n.irlow = 1'b0;
          n.hist = {hb, p.hist[7:1]};
          n.rones = !hb ? '0
            : (p.rones == ABORT_ONES) ? p.rones : p.rones + 3'h1;
          if (n.hist == HDLC_FLAG)
          begin
            n.hsync = 1'b1;
            n.rcnt = '0;
          end
          else if (n.rones == ABORT_ONES)
            n.hsync = 1'b0;
          else if (p.hsync && !(p.rones == STUFF_ONES && !hb))
          begin
            n.rsh = {hb, p.rsh[9:1]};
            n.rcnt = p.rcnt + 4'h1;
            if (n.rcnt == EIGHT_BITS)
            begin
              n.rcnt = '0;
              n.rbuf = {1'b0, n.rsh[9:2]};
              n.rfull = 1'b1;
              n.ev_rx = 1'b1;
            end
          end
        end
      end
      else if (c.clkd)
      begin
        n.rst = RX_IDLE;
        if (samp)
        begin
          n.rsh = rsh_in;
          n.rcnt = p.rcnt + 4'h1;
          if (n.rcnt == EIGHT_BITS)
          begin
            n.rcnt = '0;
            n.rbuf = {1'b0, 8'(rsh_in >> CLKD_SKIP)};
            n.rfull = 1'b1;
            n.ev_rx = 1'b1;
          end
        end
      end
      else
      begin
        unique case (p.rst)
          RX_IDLE:
          begin
            n.rdiv = '0;
            // A later switch to clocked or bit-synchronous mode must start
            // counting from a whole character, not from a stale count.
            n.rcnt = '0;
            if (!rb)
              n.rst = RX_START;
          end
          RX_START:
            if (p.rdiv == (per >> 1))
            begin
              n.rdiv = '0;
              n.rcnt = '0;
              n.rsh = '0;
              n.allz = 1'b1;
              n.rst = rb ? RX_IDLE : RX_BITS;
            end
          RX_BITS:
            if (p.rdiv == per - ONE16)
            begin
              n.rdiv = '0;
              if (p.rcnt != kbits)
              begin
                n.rsh = rsh_in;
                n.allz = p.allz && !rb;
                n.rcnt = p.rcnt + 4'h1;
              end
              else if (!rb && p.allz)
              begin
                n.ev_brk = 1'b1;
                n.rst = RX_BRK;
                if (!c.brkinh)
                begin
                  n.rbuf = '0;
                  n.rfull = 1'b1;
                  n.ev_rx = 1'b1;
                end
              end
              else if (!rb)
                n.rst = RX_BRK;
              else
              begin
                n.rst = RX_IDLE;
                n.rbuf = !c.addr ? {1'b0, al[7:0]}
                  : c.seven ? {al[7], 1'b0, al[6:0]} : al[8:0];
                n.rfull = 1'b1;
                n.ev_rx = 1'b1;
              end
            end
          // No new start is sought until the line is high again.
          RX_BRK:
            if (rb)
              n.rst = RX_IDLE;
          default:
            n.rst = RX_IDLE;
        endcase
      end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i)
    begin
      if (!nrst_i)
        p <= PORT_RST;
      else
        p <= n;
    end
  end

  always_comb
  begin
    ist_nxt = ist_r;
    imsk_nxt = imsk_r;
    misc_nxt = misc_r;
    if (reg_wr_i && sel == SEL_GLOBAL)
    begin
      if (off == REG_IST)
        ist_nxt = ist_r & ~reg_wdata_i[11:0];
      if (off == REG_IMSK)
        imsk_nxt = reg_wdata_i[11:0];
      if (off == REG_MISC)
        misc_nxt = reg_wdata_i[4:0];
    end
    for (int k = 0; k < NPORT; k++)
    begin
      cfg_nxt[k] = cfg_r[k];
      div_nxt[k] = div_r[k];
      if (reg_wr_i && sel == 3'(k) && off == REG_CTRL)
      begin
        cfg_nxt[k] = reg_wdata_i[6:0];
        cfg_nxt[k].hdlc = reg_wdata_i[5] && k >= FIRST_HDLC;
        cfg_nxt[k].irda = reg_wdata_i[6] && reg_wdata_i[5]
          && k >= FIRST_HDLC;
      end
      if (reg_wr_i && sel == 3'(k) && off == REG_DIV)
        div_nxt[k] = reg_wdata_i;
      // Events are ORed in after the clear, so a set in the same cycle
      // as a clear survives.
      ist_nxt[k] = ist_nxt[k] | prt[k].ev_rx;
      ist_nxt[k+NPORT] = ist_nxt[k+NPORT] | prt[k].ev_brk;
    end
    irq_nxt = |(ist_nxt & imsk_nxt);
  end

  always_comb
  begin
    rdata_nxt = '0;
    if (reg_rd_i && sel == SEL_GLOBAL)
    begin
      unique case (off)
        REG_IST: rdata_nxt = {4'h0, ist_r};
        REG_IMSK: rdata_nxt = {4'h0, imsk_r};
        REG_MISC: rdata_nxt = {11'h000, misc_r};
        REG_PINS: rdata_nxt = {8'h00, boot_cold_o, boot_valid_o, ck_s};
      endcase
    end
    else if (reg_rd_i && sel < 3'(NPORT))
    begin
      unique case (off)
        REG_DATA: rdata_nxt = {7'h00, prt[sel].rbuf};
        REG_CTRL: rdata_nxt = {9'h000, cfg_r[sel]};
        REG_DIV: rdata_nxt = div_r[sel];
        REG_STAT: rdata_nxt = {13'h0000, prt[sel].rst == RX_BRK,
          prt[sel].rfull, prt[sel].tlen != '0};
      endcase
    end
  end

  // The boot straps are taken once, after the synchronisers have filled
  // with real pin values rather than their reset level.
  always_comb
  begin
    bwait_nxt = bwait_r;
    cold_nxt = boot_cold_o;
    valid_nxt = boot_valid_o;
    if (!boot_valid_o)
    begin
      if (bwait_r == BOOT_WAIT)
      begin
        valid_nxt = 1'b1;
        cold_nxt = bsel == BOOT_COLD;
      end
      else
        bwait_nxt = bwait_r + 2'h1;
    end
    unique case (misc_r.stmode)
      ST_FETCH: status_nxt = !first_fetch_i;
      ST_INTACK: status_nxt = !int_ack_i;
      default: status_nxt = misc_r.gpo;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int k = 0; k < NPORT; k++)
      begin
        cfg_r[k] <= (k == PORT_B) ? CFG_RST_B : CFG_RST;
        div_r[k] <= DIV_RST;
      end
      ist_r <= '0;
      imsk_r <= '0;
      misc_r <= '0;
      reg_rdata_o <= '0;
      irq_o <= 1'b0;
      bwait_r <= '0;
      boot_cold_o <= 1'b0;
      boot_valid_o <= 1'b0;
      status_n_o <= 1'b1;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      div_r <= div_nxt;
      ist_r <= ist_nxt;
      imsk_r <= imsk_nxt;
      misc_r <= misc_nxt;
      reg_rdata_o <= rdata_nxt;
      irq_o <= irq_nxt;
      bwait_r <= bwait_nxt;
      boot_cold_o <= cold_nxt;
      boot_valid_o <= valid_nxt;
      status_n_o <= status_nxt;
    end
  end
endmodule

`default_nettype wire

//--- mms_serial_ports_assertions.sv
// Checker for the six-port serial block, fed from the top-level ports only.
// Assumes port A stays asynchronous and port B keeps its reset setup.
`timescale 1ns/1ps
`default_nettype none
module mms_serial_ports_chk
  import mms_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [AW-1:0] reg_addr_i,
  input wire logic [DW-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [DW-1:0] reg_rdata_o,
  input wire logic irq_o,
  input wire logic [NPORT-1:0] shift_clk_o,
  input wire logic [NPORT-1:0] shift_clk_oe_o,
  input wire logic boot_select_0_i,
  input wire logic boot_select_1_i,
  input wire logic boot_cold_o,
  input wire logic boot_valid_o,
  input wire logic first_fetch_i,
  input wire logic int_ack_i,
  input wire logic status_n_o
);
  logic [4:0] misc_r, misc_nxt;
  logic [11:0] mask_r, mask_nxt;
  // Shadows of the misc and mask registers, rebuilt from bus writes.
  always_comb
  begin
    misc_nxt = misc_r;
    mask_nxt = mask_r;
    if (reg_wr_i && reg_addr_i == {SEL_GLOBAL, REG_MISC})
      misc_nxt = reg_wdata_i[4:0];
    if (reg_wr_i && reg_addr_i == {SEL_GLOBAL, REG_IMSK})
      mask_nxt = reg_wdata_i[11:0];
  end
  always_ff @(posedge clk_sys_i or negedge nrst_i)
    if (!nrst_i)
      {misc_r, mask_r} <= '0;
    else
      {misc_r, mask_r} <= {misc_nxt, mask_nxt};

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  sequence unmapped_rd;
    reg_rd_i && reg_addr_i[4:2] == 3'h7;
  endsequence
  sequence fetch_seen;
    misc_r[4:3] == ST_FETCH && first_fetch_i;
  endsequence
  sequence ack_seen;
    misc_r[4:3] == ST_INTACK && int_ack_i;
  endsequence

  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == '0)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (unmapped_rd |=> reg_rdata_o == '0)
    else $error("unmapped read returned data");
  boot_rise_a: assert property ($rose(nrst_i) |-> ##[1:8] boot_valid_o)
    else $error("boot straps not captured in time");
  boot_hold_a: assert property (boot_valid_o |=> boot_valid_o)
    else $error("boot valid dropped");
  boot_code_a: assert property (boot_valid_o |->
    boot_cold_o == (!boot_select_0_i && !boot_select_1_i))
    else $error("boot mode does not follow straps");
  flash_clk_a: assert property ($past(nrst_i) |-> shift_clk_oe_o[PORT_B])
    else $error("flash clock not driven");
  gpio_oe_a: assert property (misc_r[0] [*2] |-> shift_clk_oe_o[PORT_A])
    else $error("port A clock pin not enabled");
  gpio_off_a: assert property (!misc_r[0] [*2] |-> !shift_clk_oe_o[PORT_A])
    else $error("port A clock pin driven");
  gpio_low_a: assert property ((misc_r[1:0] == 2'h1) [*2] |->
    !shift_clk_o[PORT_A])
    else $error("port A clock pin level wrong");
  status_fetch_a: assert property (fetch_seen |=> !status_n_o)
    else $error("status not low after fetch");
  status_ack_a: assert property (ack_seen |=> !status_n_o)
    else $error("status not low after acknowledge");
  status_quiet_a: assert property (!misc_r[4] && !first_fetch_i &&
    !int_ack_i |=> status_n_o)
    else $error("status low without cause");
  status_gpo_a: assert property ((misc_r[4] && !misc_r[2]) [*2] |->
    !status_n_o)
    else $error("status not following GPO value");
  irq_mask_a: assert property (irq_o |-> mask_r != '0 || $past(mask_r) != '0)
    else $error("interrupt with all sources masked");
endmodule
`default_nettype wire

//--- mms_peer_model.sv
// Far-side serial transceiver for one asynchronous port.
// Assumes bit times given in system clock cycles; its line idles high.
`timescale 1ns/1ps
`default_nettype none
module mms_peer (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  task automatic send(input logic [8:0] v, input int n, input int bt);
    line_o <= 1'b0;
    repeat (bt) @(posedge clk_i);
    for (int i = 0; i < n; i++)
    begin
      line_o <= v[i];
      repeat (bt) @(posedge clk_i);
    end
    line_o <= 1'b1;
    repeat (bt) @(posedge clk_i);
  endtask
  // A line held low is what the receiver takes for a break.
  task automatic low(input int cyc);
    line_o <= 1'b0;
    repeat (cyc) @(posedge clk_i);
    line_o <= 1'b1;
  endtask
  // Samples mid-bit; returns start, the data bits, then the stop bit.
  task automatic grab(input int n, input int bt, output logic [10:0] v);
    int i;
    v = '1;
    i = 0;
    while (line_i !== 1'b0 && i < 400)
    begin
      @(negedge clk_i);
      i++;
    end
    repeat (bt / 2) @(negedge clk_i);
    v[0] = line_i;
    for (i = 1; i <= n + 1; i++)
    begin
      repeat (bt) @(negedge clk_i);
      v[i] = line_i;
    end
  endtask
endmodule
`default_nettype wire

//--- mms_serial_ports_test.sv
// Self-checking bench: port C against a peer transceiver, port E looped
// into port F, plus boot, status, port A and port B pins. Assumes the
// block's register map.
`timescale 1ns/1ps
`default_nettype none
module mms_serial_ports_test
  import mms_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [AW-1:0] addr = '0;
  logic [DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NPORT-1:0] sclk_in = '0;
  logic ff = 1'b0;
  logic ia = 1'b0;
  logic [DW-1:0] rdata;
  logic irq, cold, valid, st_n, peer_tx;
  logic [NPORT-1:0] sout, sck, sck_oe;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 28;
  int cyc = 0;
  always #50 clk = ~clk;
  mms_serial_ports i_dut (.clk_sys_i(clk), .nrst_i(nrst),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .irq_o(irq),
    .serial_in_i({sout[4], 2'h3, peer_tx, 2'h3}),
    .serial_out_o(sout), .shift_clk_i(sclk_in), .shift_clk_o(sck),
    .shift_clk_oe_o(sck_oe), .receive_clk_i({sck[4], 1'b1}),
    .boot_select_0_i(1'b0), .boot_select_1_i(1'b0), .boot_cold_o(cold),
    .boot_valid_o(valid),
    .first_fetch_i(ff), .int_ack_i(ia), .status_n_o(st_n));
  mms_peer i_peer (.clk_i(clk), .line_i(sout[2]), .line_o(peer_tx));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic complete_run();
    $display("Counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [10:0] frame(input logic [8:0] s, input int n);
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < n; i++)
      frame[i + 1] = s[i];
  endfunction
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_errors++;
      $display("[ERR] %0t ns: run hung", $time);
      complete_run();
    end
  end

  initial
  begin
    logic [15:0] r;
    logic [10:0] v;
    logic [8:0] s;
    logic [7:0] d;
    logic mk;
    int n;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(sout, 6'h3f);
    rd_reg({3'h1, REG_CTRL}, r);
    chk(r, 16'h0008);
    rd_reg({3'h0, REG_DIV}, r);
    chk(r, DIV_RST);
    rd_reg(5'h1c, r);
    chk(r, 16'h0000);
    chk(sck_oe[1], 1'b1);
    d = 8'($random(seed));
    wr_reg({3'h1, REG_DATA}, {8'h00, d});
    repeat (4) @(posedge clk);
    #1;
    chk({sck[1], sout[1]}, {1'b0, d[0]});
    repeat (140) @(posedge clk);
    chk(sck[1], 1'b1);
    $display("reset and flash port test done");
    wr_reg({SEL_GLOBAL, REG_IMSK}, 16'h0fff);
    // Divider values below eight must still give an eight-clock bit.
    for (int c = 0; c < 4; c++)
    begin
      wr_reg({3'h2, REG_CTRL}, {13'h0, c[1], 1'b0, c[0]});
      wr_reg({3'h2, REG_DIV}, {13'h0, 3'($random(seed))});
      d = 8'($random(seed));
      mk = 1'($random(seed)) & c[1];
      n = (c[0] ? 7 : 8) + c[1];
      s = c[0] ? {1'b0, mk, d[6:0]} : {mk, d};
      wr_reg({3'h2, REG_DATA}, {7'h0, mk, d});
      i_peer.grab(n, 8, v);
      chk(v, frame(s, n));
      i_peer.send(s, n, 8);
      rd_reg({3'h2, REG_STAT}, r);
      for (int i = 0; i < 40 && r[1] !== 1'b1; i++)
        rd_reg({3'h2, REG_STAT}, r);
      chk(irq, 1'b1);
      rd_reg({3'h2, REG_DATA}, r);
      chk(r, {7'h0, mk, c[0] ? {1'b0, d[6:0]} : d});
      wr_reg({SEL_GLOBAL, REG_IST}, 16'h0fff);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
    end
    $display("async frame test done");
    wr_reg({SEL_GLOBAL, REG_IMSK}, 16'h0000);
    for (int b = 0; b < 2; b++)
    begin
      wr_reg({3'h2, REG_CTRL}, {14'h0, b[0], 1'b0});
      i_peer.low(160);
      repeat (40) @(posedge clk);
      rd_reg({SEL_GLOBAL, REG_IST}, r);
      chk(r, {7'h0, 1'b1, 5'h0, ~b[0], 2'h0});
      chk(irq, 1'b0);
      rd_reg({3'h2, REG_STAT}, r);
      chk(r[2:0], {1'b0, ~b[0], 1'b0});
      wr_reg({SEL_GLOBAL, REG_IST}, 16'h0fff);
      rd_reg({3'h2, REG_DATA}, r);
    end
    $display("break test done");
    chk({valid, cold}, 2'h3);
    sclk_in <= 6'($random(seed));
    repeat (4) @(posedge clk);
    rd_reg({SEL_GLOBAL, REG_PINS}, r);
    chk(r, {8'h0, 2'h3, sclk_in});
    for (int m = 0; m < 2; m++)
    begin
      wr_reg({SEL_GLOBAL, REG_MISC}, {11'h0, m[1:0], 3'h0});
      @(posedge clk);
      ff <= (m == 1);
      ia <= (m == 0);
      @(posedge clk);
      ff <= (m == 0);
      ia <= (m == 1);
      #1;
      chk(st_n, 1'b1);
      @(posedge clk);
      ff <= 1'b0;
      ia <= 1'b0;
      #1;
      chk(st_n, 1'b0);
    end
    wr_reg({SEL_GLOBAL, REG_MISC}, 16'h0011);
    repeat (2) @(posedge clk);
    #1;
    chk({st_n, sck_oe[0], sck[0]}, 3'h2);
    wr_reg({SEL_GLOBAL, REG_MISC}, 16'h0016);
    repeat (2) @(posedge clk);
    #1;
    chk({st_n, sck_oe[0]}, 2'h2);
    $display("boot, status and pin test done");
    // Port E sends into port F, which is clocked by port E's transmit
    // clock; the all-ones byte forces a stuffed zero.
    for (int h = 0; h < 2; h++)
    begin
      wr_reg({3'h4, REG_CTRL}, {9'h0, h[0], 6'h20});
      wr_reg({3'h5, REG_CTRL}, {9'h0, h[0], 6'h20});
      d = (h == 0) ? 8'hff : 8'($random(seed));
      wr_reg({3'h4, REG_DATA}, {8'h00, d});
      repeat (440) @(posedge clk);
      rd_reg({3'h5, REG_DATA}, r);
      chk(r, {8'h00, d});
    end
    $display("bit-synchronous loop test done");
    // Port C shifts on a clock from the far side; the idle peer line
    // reads back as all ones.
    sclk_in <= '0;
    wr_reg({3'h2, REG_CTRL}, 16'h0018);
    d = 8'($random(seed));
    wr_reg({3'h2, REG_DATA}, {8'h00, d});
    for (int k = 0; k < 8; k++)
    begin
      repeat (4) @(posedge clk);
      chk(sout[2], d[k]);
      sclk_in[2] <= 1'b1;
      repeat (4) @(posedge clk);
      sclk_in[2] <= 1'b0;
    end
    repeat (4) @(posedge clk);
    rd_reg({3'h2, REG_DATA}, r);
    chk(r, 16'h00ff);
    $display("external clock test done");
    complete_run();
  end
endmodule

bind mms_serial_ports mms_serial_ports_chk i_chk (.clk_sys_i(clk_sys_i),
  .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .irq_o(irq_o), .shift_clk_o(shift_clk_o), .shift_clk_oe_o(shift_clk_oe_o),
  .boot_select_0_i(boot_select_0_i), .boot_select_1_i(boot_select_1_i),
  .boot_cold_o(boot_cold_o), .boot_valid_o(boot_valid_o),
  .first_fetch_i(first_fetch_i), .int_ack_i(int_ack_i),
  .status_n_o(status_n_o));
`default_nettype wire
